/* File: inc/cassc_pkg.sv */
package cassc_pkg;

  // register bus
  localparam int          CASSC_AW             = 8;
  localparam int          CASSC_DW             = 32;
  localparam logic [7:0]  CASSC_OFF_MODE       = 8'h00;
  localparam logic [7:0]  CASSC_OFF_CFG        = 8'h04;
  localparam logic [7:0]  CASSC_OFF_ATTACK     = 8'h08;
  localparam logic [7:0]  CASSC_OFF_CMD        = 8'h0c;
  localparam logic [7:0]  CASSC_OFF_STATUS     = 8'h10;
  localparam logic [7:0]  CASSC_OFF_MODE_ACT   = 8'h14;
  localparam logic [7:0]  CASSC_OFF_CFG_ACT    = 8'h18;

  // command bits
  localparam int          CASSC_CMD_APPLY_BIT  = 0;
  localparam int          CASSC_CMD_DROP_BIT   = 1;

  // mode register: five 2-bit fields, A..D toward the subscriber, then hook
  localparam int          CASSC_MODE_W         = 10;
  localparam int          CASSC_MODE_HOOK_LSB  = 8;
  localparam logic [9:0]  CASSC_MODE_RST       = 10'h000;

  // cfg register fields
  localparam int          CASSC_CFG_RING_LSB   = 0;
  localparam int          CASSC_CFG_BFREQ_BIT  = 2;
  localparam int          CASSC_CFG_LEVEL_LSB  = 3;
  localparam int          CASSC_CFG_IMP_LSB    = 5;
  localparam int          CASSC_CFG_SRC_BIT    = 8;
  localparam logic [1:0]  CASSC_RING_RST       = 2'h1;
  localparam logic        CASSC_BFREQ_RST      = 1'b1;
  localparam logic [1:0]  CASSC_LEVEL_RST      = 2'h1;
  localparam logic [2:0]  CASSC_IMP_RST        = 3'h0;
  localparam logic        CASSC_SRC_RST        = 1'b0;
  localparam logic [3:0]  CASSC_ATTACK_RST     = 4'h1;

  // status fields
  localparam int          CASSC_STAT_HOOK_LSB  = 8;
  localparam int          CASSC_STAT_ERR_BIT   = 10;

  // per-bit signalling modes
  typedef enum logic [1:0] {
    CASSC_PASS_NORM = 2'b00,
    CASSC_PASS_INV  = 2'b01,
    CASSC_FORCE_ONE = 2'b10,
    CASSC_FORCE_ZERO = 2'b11
  } cassc_mode_e;

  // ringing frequency codes, code 3 is illegal
  localparam logic [1:0]  CASSC_RING_17HZ      = 2'h0;
  localparam logic [1:0]  CASSC_RING_25HZ      = 2'h1;
  localparam logic [1:0]  CASSC_RING_50HZ      = 2'h2;

  // billing tone level codes
  localparam logic [1:0]  CASSC_LEV_400MV      = 2'h0;
  localparam logic [1:0]  CASSC_LEV_300MV      = 2'h1;
  localparam logic [1:0]  CASSC_LEV_200MV      = 2'h2;
  localparam logic [1:0]  CASSC_LEV_100MV      = 2'h3;

  // impedance codes, code 7 is illegal
  localparam logic [2:0]  CASSC_IMP_600        = 3'h0;
  localparam logic [2:0]  CASSC_IMP_600_CAP    = 3'h1;
  localparam logic [2:0]  CASSC_IMP_900        = 3'h2;
  localparam logic [2:0]  CASSC_IMP_900_CAP    = 3'h3;
  localparam logic [2:0]  CASSC_IMP_AUS        = 3'h4;
  localparam logic [2:0]  CASSC_IMP_WIDE       = 3'h5;
  localparam logic [2:0]  CASSC_IMP_NZ         = 3'h6;

  // timing
  localparam int          CASSC_CLK_HZ         = 10_000_000;
  localparam int          CASSC_ATTACK_UNIT_US = 1000;
  localparam int          CASSC_RAMP_STEPS     = 256;
  localparam int          CASSC_RAMP_STEP_CYC  =
    (CASSC_ATTACK_UNIT_US * (CASSC_CLK_HZ / 1_000_000)) / CASSC_RAMP_STEPS;
  localparam logic [7:0]  CASSC_AMPL_FULL      = 8'hff;

  function automatic logic cassc_cond(input logic in_bit, input logic [1:0] mode);
    logic r;
    r = in_bit;
    case (mode)
      CASSC_PASS_NORM: r = in_bit;
      CASSC_PASS_INV:  r = ~in_bit;
      CASSC_FORCE_ONE: r = 1'b1;
      default:         r = 1'b0;
    endcase
    return r;
  endfunction : cassc_cond

  // level allowed by impedance; 600 and 900 families include the capacitor variants
  function automatic logic cassc_cfg_ok(input logic [1:0] ring, input logic [1:0] lev,
                                        input logic [2:0] imp);
    logic cplx;
    logic f600;
    logic f900;
    cplx = (imp == CASSC_IMP_AUS) || (imp == CASSC_IMP_WIDE) || (imp == CASSC_IMP_NZ);
    f600 = (imp == CASSC_IMP_600) || (imp == CASSC_IMP_600_CAP);
    f900 = (imp == CASSC_IMP_900) || (imp == CASSC_IMP_900_CAP);
    return (ring != 2'h3) && (imp != 3'h7) &&
           ((lev == CASSC_LEV_100MV) ||
            (lev == CASSC_LEV_200MV && (cplx || f600 || f900)) ||
            (lev == CASSC_LEV_300MV && (cplx || f600)) ||
            (lev == CASSC_LEV_400MV && cplx));
  endfunction : cassc_cfg_ok

endpackage : cassc_pkg

/* File: core/cassc_top.sv */
// Operation
// - pass normal copies CAS bit unchanged
// - pass inverted outputs the bit's complement
// - force one drives constant logic 1
// - force zero drives constant logic 0
// - separate mode per ABCD bit and hook
// - one mode set shared by both ports
// - exchange A bit 1 means fault
// - exchange B bit 0 means ringing
// - exchange C bit 0 means billing tone
// - exchange D bit 0 means polarity reversal
// - hook A bit 0 means off hook
// - trunk feed: A bit 0 rings, BCD unused
// - to trunk: 1 idle, 0 off hook
// - ringing 17/25/50 Hz, default 25 Hz
// - billing tone 12/16 kHz, default 16 kHz
// - billing tone ramps up over attack time
// - billing level limited by impedance choice
// - seven impedances, one code for both, 600 default
`timescale 1ns/10ps
module cassc_top
  import cassc_pkg::*;
(
  // clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RST,
  // register port
  input  wire logic [CASSC_AW-1:0]   ADDR,
  input  wire logic [CASSC_DW-1:0]   WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic      [CASSC_DW-1:0]   RDATA,
  // signalling in: link CAS with port p in bits 4p+3..4p (A at 4p), off hook one bit per port
  input  wire logic [7:0]            CAS_IN,
  input  wire logic [1:0]            OFF_HOOK_IN,
  // conditioned signalling
  output logic      [7:0]            CAS_TO_SUB,
  output logic      [1:0]            HOOK_A_OUT,
  // line functions per port
  output logic      [1:0]            FAULT,
  output logic      [1:0]            RING_ON,
  output logic      [1:0]            BILL_ON,
  output logic      [1:0]            REVERSE_ON,
  output logic      [15:0]           BILL_AMPL,
  // active card settings
  output logic      [1:0]            RING_FREQ_SEL,
  output logic                       BILL_FREQ_SEL,
  output logic      [1:0]            BILL_LEVEL_SEL,
  output logic      [2:0]            IMPEDANCE_SEL
);

  typedef struct packed {
    logic [9:0]  mode_stg;
    logic [9:0]  mode_act;
    logic [1:0]  ring_stg;
    logic [1:0]  ring_act;
    logic        bfreq_stg;
    logic        bfreq_act;
    logic [1:0]  lev_stg;
    logic [1:0]  lev_act;
    logic [2:0]  imp_stg;
    logic [2:0]  imp_act;
    logic        src_stg;
    logic        src_act;
    logic [3:0]  atk_stg;
    logic [3:0]  atk_act;
    logic        cfg_err;
    logic [31:0] rdata;
    logic [7:0]  cas_out;
    logic [1:0]  hook_out;
    logic [1:0]  fault;
    logic [1:0]  ring;
    logic [1:0]  bill;
    logic [1:0]  rev;
    logic [5:0]  tick_cnt;
    logic [7:0]  sub_cnt;
    logic [15:0] ampl;
  } cassc_state_s;

  localparam logic [5:0] STEP_LAST = 6'(CASSC_RAMP_STEP_CYC - 1);

  cassc_state_s st_reg;
  cassc_state_s st_next;
  logic         tick;
  logic         hit;
  logic [31:0]  cfg_stg_word;
  logic [31:0]  cfg_act_word;

  assign tick = (st_reg.tick_cnt == STEP_LAST);
  assign hit  = WR && (ADDR == CASSC_OFF_CMD);
  assign cfg_stg_word = {23'h000000, st_reg.src_stg, st_reg.imp_stg, st_reg.lev_stg,
                         st_reg.bfreq_stg, st_reg.ring_stg};
  assign cfg_act_word = {23'h000000, st_reg.src_act, st_reg.imp_act, st_reg.lev_act,
                         st_reg.bfreq_act, st_reg.ring_act};

  always_comb begin
    logic       b_now;
    logic [1:0] m;
    st_next = st_reg;
    b_now   = 1'b0;
    m       = 2'h0;

    // staged edits
    if (WR) begin
      unique case (ADDR)
        CASSC_OFF_MODE: st_next.mode_stg = WDATA[CASSC_MODE_W-1:0];
        CASSC_OFF_CFG: begin
          st_next.ring_stg  = WDATA[CASSC_CFG_RING_LSB +: 2];
          st_next.bfreq_stg = WDATA[CASSC_CFG_BFREQ_BIT];
          st_next.lev_stg   = WDATA[CASSC_CFG_LEVEL_LSB +: 2];
          st_next.imp_stg   = WDATA[CASSC_CFG_IMP_LSB +: 3];
          st_next.src_stg   = WDATA[CASSC_CFG_SRC_BIT];
        end
        CASSC_OFF_ATTACK: st_next.atk_stg = WDATA[3:0];
        default: ;
      endcase
    end

    // apply commits checked edits, drop restores the active set
    if (hit && WDATA[CASSC_CMD_APPLY_BIT]) begin
      if (cassc_cfg_ok(st_reg.ring_stg, st_reg.lev_stg, st_reg.imp_stg)) begin
        st_next.mode_act  = st_reg.mode_stg;
        st_next.ring_act  = st_reg.ring_stg;
        st_next.bfreq_act = st_reg.bfreq_stg;
        st_next.lev_act   = st_reg.lev_stg;
        st_next.imp_act   = st_reg.imp_stg;
        st_next.src_act   = st_reg.src_stg;
        st_next.atk_act   = st_reg.atk_stg;
        st_next.cfg_err   = 1'b0;
      end else begin
        st_next.cfg_err = 1'b1;
      end
    end else if (hit && WDATA[CASSC_CMD_DROP_BIT]) begin
      st_next.mode_stg  = st_reg.mode_act;
      st_next.ring_stg  = st_reg.ring_act;
      st_next.bfreq_stg = st_reg.bfreq_act;
      st_next.lev_stg   = st_reg.lev_act;
      st_next.imp_stg   = st_reg.imp_act;
      st_next.src_stg   = st_reg.src_act;
      st_next.atk_stg   = st_reg.atk_act;
    end

    // read data for the cycle after the strobe
    st_next.rdata = 32'h00000000;
    if (RD) begin
      unique case (ADDR)
        CASSC_OFF_MODE:     st_next.rdata = {22'h000000, st_reg.mode_stg};
        CASSC_OFF_CFG:      st_next.rdata = cfg_stg_word;
        CASSC_OFF_ATTACK:   st_next.rdata = {28'h0000000, st_reg.atk_stg};
        CASSC_OFF_STATUS:   st_next.rdata = {21'h000000, st_reg.cfg_err, st_reg.hook_out, st_reg.cas_out};
        CASSC_OFF_MODE_ACT: st_next.rdata = {22'h000000, st_reg.mode_act};
        CASSC_OFF_CFG_ACT:  st_next.rdata = {cfg_act_word[31:12], st_reg.atk_act, cfg_act_word[7:0]}
                                            | {23'h000000, st_reg.src_act, 8'h00};
        default:            st_next.rdata = 32'h00000000;
      endcase
    end

    // ramp prescaler shared by both ports
    st_next.tick_cnt = tick ? 6'h00 : st_reg.tick_cnt + 6'h01;

    // signalling: one mode set serves both ports
    for (int p = 0; p < 2; p++) begin
      for (int b = 0; b < 4; b++) begin
        m = st_reg.mode_act[2*b +: 2];
        st_next.cas_out[4*p+b] = cassc_cond(CAS_IN[4*p+b], m);
      end
      m = st_reg.mode_act[CASSC_MODE_HOOK_LSB +: 2];
      st_next.hook_out[p] = cassc_cond(~OFF_HOOK_IN[p], m);
      if (st_reg.src_act) begin
        st_next.fault[p] = 1'b0;
        st_next.ring[p]  = ~st_next.cas_out[4*p];
        st_next.bill[p]  = 1'b0;
        st_next.rev[p]   = 1'b0;
      end else begin
        st_next.fault[p] = st_next.cas_out[4*p];
        st_next.ring[p]  = ~st_next.cas_out[4*p+1];
        st_next.bill[p]  = ~st_next.cas_out[4*p+2];
        st_next.rev[p]   = ~st_next.cas_out[4*p+3];
      end

      // billing tone attack: one amplitude step every atk_act prescaler ticks
      b_now = st_reg.bill[p];
      if (!b_now) begin
        st_next.ampl[8*p +: 8]    = 8'h00;
        st_next.sub_cnt[4*p +: 4] = 4'h0;
      end else if (st_reg.atk_act == 4'h0) begin
        st_next.ampl[8*p +: 8] = CASSC_AMPL_FULL;
      end else if (tick && st_reg.ampl[8*p +: 8] != CASSC_AMPL_FULL) begin
        if (st_reg.sub_cnt[4*p +: 4] >= st_reg.atk_act - 4'h1) begin
          st_next.sub_cnt[4*p +: 4] = 4'h0;
          st_next.ampl[8*p +: 8]    = st_reg.ampl[8*p +: 8] + 8'h01;
        end else begin
          st_next.sub_cnt[4*p +: 4] = st_reg.sub_cnt[4*p +: 4] + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_reg           <= '0;
      st_reg.mode_stg  <= CASSC_MODE_RST;
      st_reg.mode_act  <= CASSC_MODE_RST;
      st_reg.ring_stg  <= CASSC_RING_RST;
      st_reg.ring_act  <= CASSC_RING_RST;
      st_reg.bfreq_stg <= CASSC_BFREQ_RST;
      st_reg.bfreq_act <= CASSC_BFREQ_RST;
      st_reg.lev_stg   <= CASSC_LEVEL_RST;
      st_reg.lev_act   <= CASSC_LEVEL_RST;
      st_reg.imp_stg   <= CASSC_IMP_RST;
      st_reg.imp_act   <= CASSC_IMP_RST;
      st_reg.src_stg   <= CASSC_SRC_RST;
      st_reg.src_act   <= CASSC_SRC_RST;
      st_reg.atk_stg   <= CASSC_ATTACK_RST;
      st_reg.atk_act   <= CASSC_ATTACK_RST;
      st_reg.cas_out   <= 8'hff;
      st_reg.hook_out  <= 2'h3;
    end else begin
      st_reg <= st_next;
    end
  end

  assign RDATA          = st_reg.rdata;
  assign CAS_TO_SUB     = st_reg.cas_out;
  assign HOOK_A_OUT     = st_reg.hook_out;
  assign FAULT          = st_reg.fault;
  assign RING_ON        = st_reg.ring;
  assign BILL_ON        = st_reg.bill;
  assign REVERSE_ON     = st_reg.rev;
  assign BILL_AMPL      = st_reg.ampl;
  assign RING_FREQ_SEL  = st_reg.ring_act;
  assign BILL_FREQ_SEL  = st_reg.bfreq_act;
  assign BILL_LEVEL_SEL = st_reg.lev_act;
  assign IMPEDANCE_SEL  = st_reg.imp_act;

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_bill_start;
    !BILL_ON[0] ##1 BILL_ON[0];
  endsequence

  sequence s_apply_bad;
    hit && WDATA[CASSC_CMD_APPLY_BIT] &&
      !cassc_cfg_ok(st_reg.ring_stg, st_reg.lev_stg, st_reg.imp_stg);
  endsequence

  sequence s_apply_good;
    hit && WDATA[CASSC_CMD_APPLY_BIT] &&
      cassc_cfg_ok(st_reg.ring_stg, st_reg.lev_stg, st_reg.imp_stg);
  endsequence

  property p_pass_norm;
    st_reg.mode_act[1:0] == CASSC_PASS_NORM ##0 $stable(st_reg.mode_act) [*2]
      |-> ##0 1'b1 ##1 CAS_TO_SUB[0] == $past(CAS_IN[0]);
  endproperty
  a_pass_norm: assert property (p_pass_norm) else $error("pass normal altered bit");

  property p_pass_inv;
    st_reg.mode_act[3:2] == CASSC_PASS_INV |=> CAS_TO_SUB[5] == ~$past(CAS_IN[5]);
  endproperty
  a_pass_inv: assert property (p_pass_inv) else $error("pass inverted not complemented");

  property p_force_one;
    st_reg.mode_act[5:4] == CASSC_FORCE_ONE |=> CAS_TO_SUB[2] && CAS_TO_SUB[6];
  endproperty
  a_force_one: assert property (p_force_one) else $error("force one not high");

  property p_force_zero;
    st_reg.mode_act[7:6] == CASSC_FORCE_ZERO |=> !CAS_TO_SUB[3] && !CAS_TO_SUB[7];
  endproperty
  a_force_zero: assert property (p_force_zero) else $error("force zero not low");

  property p_ports_same;
    CAS_IN[3:0] == CAS_IN[7:4] |=> CAS_TO_SUB[3:0] == CAS_TO_SUB[7:4];
  endproperty
  a_ports_same: assert property (p_ports_same) else $error("ports conditioned differently");

  property p_hook;
    st_reg.mode_act[9:8] == CASSC_PASS_NORM && OFF_HOOK_IN[1] |=> !HOOK_A_OUT[1];
  endproperty
  a_hook: assert property (p_hook) else $error("off hook not sent as zero");

  property p_exch_map;
    !st_reg.src_act |=> FAULT[0] == CAS_TO_SUB[0] && RING_ON[0] == !CAS_TO_SUB[1] &&
                        BILL_ON[0] == !CAS_TO_SUB[2] && REVERSE_ON[0] == !CAS_TO_SUB[3];
  endproperty
  a_exch_map: assert property (p_exch_map) else $error("exchange bit meaning wrong");

  property p_trunk_map;
    st_reg.src_act && $stable(st_reg.src_act) |->
      RING_ON[1] == !CAS_TO_SUB[4] && !BILL_ON[1] && !REVERSE_ON[1] && !FAULT[1];
  endproperty
  a_trunk_map: assert property (p_trunk_map) else $error("trunk ring meaning wrong");

  property p_ramp_start;
    s_bill_start ##0 st_reg.atk_act != 4'h0 |-> BILL_AMPL[7:0] == 8'h00 ##1 BILL_AMPL[7:0] <= 8'h01;
  endproperty
  a_ramp_start: assert property (p_ramp_start) else $error("billing tone started at full");

  property p_apply_reject;
    s_apply_bad |=> st_reg.cfg_err && $stable(IMPEDANCE_SEL) && $stable(BILL_LEVEL_SEL);
  endproperty
  a_apply_reject: assert property (p_apply_reject) else $error("bad setting was applied");

  property p_no_commit;
    !hit |=> $stable(RING_FREQ_SEL) && $stable(st_reg.mode_act);
  endproperty
  a_no_commit: assert property (p_no_commit) else $error("setting changed without apply");

  property p_read_once;
    RD && ADDR == CASSC_OFF_STATUS |=> RDATA[7:0] == $past(st_reg.cas_out) ##1 ($past(RD) || RDATA == 32'h0);
  endproperty
  a_read_once: assert property (p_read_once) else $error("status read data wrong");

  property p_trunk_idle;
    st_reg.mode_act[9:8] == CASSC_PASS_NORM && !OFF_HOOK_IN[0] |=> HOOK_A_OUT[0];
  endproperty
  a_trunk_idle: assert property (p_trunk_idle) else $error("on hook not sent as one");

  property p_hook_zero;
    st_reg.mode_act[9:8] == CASSC_FORCE_ZERO |=> HOOK_A_OUT == 2'h0;
  endproperty
  a_hook_zero: assert property (p_hook_zero) else $error("forced hook bit not low");

  property p_fields_apart;
    st_reg.mode_act[3:0] == 4'h4 |=> CAS_TO_SUB[0] == $past(CAS_IN[0]) && CAS_TO_SUB[1] == ~$past(CAS_IN[1]);
  endproperty
  a_fields_apart: assert property (p_fields_apart) else $error("mode fields not independent");

  property p_ring_legal;
    RING_FREQ_SEL != 2'h3;
  endproperty
  a_ring_legal: assert property (p_ring_legal) else $error("illegal ringing frequency active");

  property p_imp_legal;
    IMPEDANCE_SEL != 3'h7;
  endproperty
  a_imp_legal: assert property (p_imp_legal) else $error("illegal impedance active");

  property p_level_400;
    BILL_LEVEL_SEL == CASSC_LEV_400MV |->
      IMPEDANCE_SEL == CASSC_IMP_AUS || IMPEDANCE_SEL == CASSC_IMP_WIDE || IMPEDANCE_SEL == CASSC_IMP_NZ;
  endproperty
  a_level_400: assert property (p_level_400) else $error("top billing level on a plain impedance");

  property p_level_300;
    BILL_LEVEL_SEL == CASSC_LEV_300MV |-> IMPEDANCE_SEL != CASSC_IMP_900 && IMPEDANCE_SEL != CASSC_IMP_900_CAP;
  endproperty
  a_level_300: assert property (p_level_300) else $error("billing level too high for 900 ohm");

  property p_apply_commit;
    s_apply_good |=> RING_FREQ_SEL == $past(st_reg.ring_stg) && IMPEDANCE_SEL == $past(st_reg.imp_stg) &&
                     st_reg.mode_act == $past(st_reg.mode_stg) && !st_reg.cfg_err;
  endproperty
  a_apply_commit: assert property (p_apply_commit) else $error("apply did not commit the edits");

  property p_drop_restore;
    hit && !WDATA[CASSC_CMD_APPLY_BIT] && WDATA[CASSC_CMD_DROP_BIT] |=>
      st_reg.mode_stg == st_reg.mode_act && st_reg.imp_stg == IMPEDANCE_SEL;
  endproperty
  a_drop_restore: assert property (p_drop_restore) else $error("discard left staged edits");

  property p_bill_off;
    !BILL_ON[0] |=> BILL_AMPL[7:0] == 8'h00;
  endproperty
  a_bill_off: assert property (p_bill_off) else $error("billing amplitude without tone");

  property p_ramp_step;
    BILL_ON[0] && st_reg.atk_act != 4'h0 |=>
      BILL_AMPL[7:0] == $past(BILL_AMPL[7:0]) || BILL_AMPL[7:0] == $past(BILL_AMPL[7:0]) + 8'h01;
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("billing tone rose faster than one step");

  property p_ramp_hold;
    BILL_ON[1] && BILL_AMPL[15:8] == CASSC_AMPL_FULL |=> BILL_AMPL[15:8] == CASSC_AMPL_FULL;
  endproperty
  a_ramp_hold: assert property (p_ramp_hold) else $error("billing tone left full level");

  property p_reset_defaults;
    $fell(RST) |-> RING_FREQ_SEL == CASSC_RING_RST && BILL_FREQ_SEL == CASSC_BFREQ_RST &&
                   BILL_LEVEL_SEL == CASSC_LEVEL_RST && IMPEDANCE_SEL == CASSC_IMP_RST && CAS_TO_SUB == 8'hff;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("settings not at defaults after reset");

endmodule : cassc_top

/* File: sim/cassc_link_model.sv */
`timescale 1ns/10ps
module cassc_link_model (
  // clock
  input  wire logic       clk,
  // requests from the bench
  input  wire logic       trunk,
  input  wire logic [7:0] cas_req,
  // link wires
  output logic      [7:0] cas_out,
  input  wire logic [1:0] hook_a,
  output logic      [1:0] off_hook_seen
);
  always_ff @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      cas_out[4*p] <= cas_req[4*p];
      // a trunk card only carries A, its spare bits sit at B=1, C=0, D=1
      cas_out[4*p+1 +: 3] <= trunk ? 3'b101 : cas_req[4*p+1 +: 3];
      off_hook_seen[p]    <= ~hook_a[p];
    end
  end
endmodule : cassc_link_model

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import cassc_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [31:0] rdata;
  logic [7:0]  cas_req = 8'hff;
  logic        trunk = 1'b0;
  logic [7:0]  cas_in;
  logic [1:0]  off_hook = 2'b00;
  logic [7:0]  cas_to_sub;
  logic [1:0]  hook_a, seen, fault, ring_on, bill_on, rev_on, ring_sel, lev_sel, pl;
  logic [15:0] ampl;
  logic        bfreq_sel;
  logic [2:0]  imp_sel, pi;
  logic [7:0]  c, e;
  logic [1:0]  o;
  logic [31:0] rv;
  logic [5:0]  lv_tab [8] = '{6'h00, 6'h24, 6'h0a, 6'h29, 6'h33, 6'h17, 6'h3e, 6'h2d};
  int          fail_count = 0;
  int          n_tests = 0;
  int          n;

  always #50 clk = ~clk;

  cassc_link_model far (.clk(clk), .trunk(trunk), .cas_req(cas_req), .cas_out(cas_in), .hook_a(hook_a),
                        .off_hook_seen(seen));

  cassc_top dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_en), .RD(rd_en), .RDATA(rdata),
                 .CAS_IN(cas_in), .OFF_HOOK_IN(off_hook), .CAS_TO_SUB(cas_to_sub), .HOOK_A_OUT(hook_a),
                 .FAULT(fault), .RING_ON(ring_on), .BILL_ON(bill_on), .REVERSE_ON(rev_on), .BILL_AMPL(ampl),
                 .RING_FREQ_SEL(ring_sel), .BILL_FREQ_SEL(bfreq_sel), .BILL_LEVEL_SEL(lev_sel),
                 .IMPEDANCE_SEL(imp_sel));

  function automatic logic cond(input logic b, input logic [1:0] m);
    return (m == 2'h0) ? b : (m == 2'h1) ? ~b : (m == 2'h2);
  endfunction : cond

  function automatic logic [31:0] mk_cfg(input logic [1:0] r, input logic b, input logic [1:0] l,
                                         input logic [2:0] i, input logic s);
    return {23'h0, s, i, l, b, r};
  endfunction : mk_cfg

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task automatic apply;
    reg_wr(CASSC_OFF_CMD, 32'h1);
    settle();
  endtask : apply

  task automatic drive(input logic [7:0] cv, input logic [1:0] ov);
    @(posedge clk);
    cas_req  <= cv;
    off_hook <= ov;
    settle();
  endtask : drive

  // expected line functions from the CAS nibble of each port
  task automatic chk_lines(input logic [7:0] cv, input logic tr);
    logic [1:0] ef, er, eb, ev;
    for (int p = 0; p < 2; p++) begin
      ef[p] = !tr & cv[4*p];
      er[p] = tr ? ~cv[4*p] : ~cv[4*p+1];
      eb[p] = !tr & ~cv[4*p+2];
      ev[p] = !tr & ~cv[4*p+3];
    end
    chk({fault, ring_on, bill_on, rev_on}, {ef, er, eb, ev});
  endtask : chk_lines

  initial begin
    #(30000 * 100);
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({ring_sel, bfreq_sel, lev_sel, imp_sel}, {CASSC_RING_25HZ, 1'b1, CASSC_LEV_300MV, CASSC_IMP_600});
    reg_rd(CASSC_OFF_CFG_ACT, rv);
    chk(rv, 32'h10d);
    reg_rd(CASSC_OFF_MODE_ACT, rv);
    chk(rv, 32'h0);
    reg_rd(8'h40, rv);
    chk(rv, 32'h0);
    // every mode on all bits of both ports and on the hook bit
    for (int m = 0; m < 4; m++) begin
      reg_wr(CASSC_OFF_MODE, {22'h0, {5{m[1:0]}}});
      apply();
      for (int k = 0; k < 2; k++) begin
        c = k ? 8'h5a : 8'ha5;
        o = k ? 2'b01 : 2'b10;
        drive(c, o);
        for (int i = 0; i < 8; i++) e[i] = cond(c[i], m[1:0]);
        chk(cas_to_sub, e);
        chk(hook_a, {cond(~o[1], m[1:0]), cond(~o[0], m[1:0])});
      end
    end
    // a different mode on each ABCD field, hook inverted like B
    reg_wr(CASSC_OFF_MODE, 32'h1e4);
    apply();
    drive(8'h00, 2'b00);
    chk({hook_a, cas_to_sub}, 10'h066);
    drive(8'hff, 2'b11);
    chk({hook_a, cas_to_sub}, 10'h355);
    // staged edits stay inert, discard brings back the active set
    reg_wr(CASSC_OFF_MODE, 32'h3ff);
    settle();
    chk(cas_to_sub, 8'h55);
    reg_wr(CASSC_OFF_CMD, 32'h2);
    reg_rd(CASSC_OFF_MODE_ACT, rv);
    chk(rv, 32'h1e4);
    reg_rd(CASSC_OFF_MODE, rv);
    chk(rv, 32'h1e4);
    reg_wr(CASSC_OFF_MODE, 32'h0);
    apply();
    drive(8'hff, 2'b01);
    chk(seen, 2'b01);
    // trunk feed first, then back to the exchange card
    for (int t = 1; t >= 0; t--) begin
      @(posedge clk);
      trunk <= t[0];
      reg_wr(CASSC_OFF_CFG, mk_cfg(2'h1, 1'b1, 2'h1, 3'h0, t[0]));
      apply();
      for (int k = 0; k < 2; k++) begin
        c = k ? 8'h69 : 8'h96;
        drive(c, 2'b00);
        chk_lines(c, t[0]);
      end
    end
    // ring code 3 is refused and keeps the 50 Hz pair
    for (int r = 0; r < 4; r++) begin
      reg_wr(CASSC_OFF_CFG, mk_cfg(r[1:0], r[0], 2'h1, 3'h0, 1'b0));
      apply();
      chk({ring_sel, bfreq_sel}, (r < 3) ? {r[1:0], r[0]} : {CASSC_RING_50HZ, 1'b0});
      reg_rd(CASSC_OFF_STATUS, rv);
      chk(rv[10], r == 3);
    end
    // level against impedance, refused applies keep the old pair
    pl = 2'h1;
    pi = 3'h0;
    for (int k = 0; k < 8; k++) begin
      reg_wr(CASSC_OFF_CFG, mk_cfg(2'h1, 1'b1, lv_tab[k][4:3], lv_tab[k][2:0], 1'b0));
      apply();
      if (lv_tab[k][5]) begin
        pl = lv_tab[k][4:3];
        pi = lv_tab[k][2:0];
      end
      chk({lev_sel, imp_sel}, {pl, pi});
      reg_rd(CASSC_OFF_STATUS, rv);
      chk(rv[10], !lv_tab[k][5]);
    end
    // billing tone ramp, zero attack then the one unit attack
    reg_wr(CASSC_OFF_ATTACK, 32'h0);
    apply();
    drive(8'hbb, 2'b00);
    chk(ampl, 16'hffff);
    drive(8'hff, 2'b00);
    chk(ampl, 16'h0000);
    reg_wr(CASSC_OFF_ATTACK, 32'h1);
    apply();
    drive(8'hfb, 2'b00);
    n = 3;
    while (ampl[7:0] !== 8'hff && n < 10200) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({31'h0, n >= 9880 && n <= 10100}, 32'h1);
    // reset in mid-run restores the defaults
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({ampl, hook_a, cas_to_sub}, 26'h00003ff);
    reg_rd(CASSC_OFF_CFG_ACT, rv);
    chk(rv, 32'h10d);
    finish_test();
  end
endmodule : tb_top
